// file: fast_counters_pkg.sv
// constants and types for the pulse rate and up/down counter block
package fast_counters_pkg;
    localparam int NUM_CH = 4;
    localparam int CLK_HZ = 40_000_000;
    // frequency gate time in milliseconds
    localparam int GATE_MS = 1000;
    localparam int GATE_CYCLES_DFLT = CLK_HZ / 1000 * GATE_MS;

    typedef logic [15:0] count_t;

    // mode codes are the ascii letters of the two functions
    localparam logic [7:0] MODE_RATE = 8'h46;
    localparam logic [7:0] MODE_UPDOWN = 8'h48;

    localparam count_t RATE_SP_MAX = 16'h03E8;
    localparam count_t UPDOWN_MAX = 16'h7D00;
    localparam count_t RATE_VALID_MIN = 16'h0004;
    localparam count_t RATE_VALID_MAX = 16'h03E8;
    localparam count_t COUNT_SAT = 16'hFFFF;

    // channel control word, bits 11:0 of the control register
    typedef struct packed {
        logic [7:0] mode;
        logic retentive;
        logic direction;
        logic reset_coil;
        logic enable;
    } chan_ctrl_t;

    localparam chan_ctrl_t CTRL_RST_UPDOWN =
        '{MODE_UPDOWN, 1'b0, 1'b0, 1'b0, 1'b0};
    localparam chan_ctrl_t CTRL_RST_RATE =
        '{MODE_RATE, 1'b0, 1'b0, 1'b0, 1'b0};

    // byte addresses; channel n occupies 0x10*n .. 0x10*n+0x0C
    localparam logic [1:0] OFS_CTRL = 2'h0;
    localparam logic [1:0] OFS_SETPOINT = 2'h1;
    localparam logic [1:0] OFS_ACTUAL = 2'h2;
    localparam logic [1:0] OFS_STATUS = 2'h3;
    localparam logic [7:0] ADDR_RUN = 8'h40;
    localparam logic [7:0] ADDR_SCAN = 8'h44;

    localparam int STAT_CONTACT = 0;
    localparam int STAT_RANGE_OK = 1;
    localparam logic RUN_RST = 1'b0;
    localparam count_t SETPOINT_RST = 16'h0000;
endpackage

// file: fast_counters.sv
// four hardware counters: two up/down pulse counters, two rate counters
//
// Contract
// RULE1: each channel holds a mode code, F for rate, H for up/down
// RULE2: rate setpoint accepts 0 to 1000, larger writes clamp to 1000
// RULE3: rate readings are valid from 4 Hz to 1000 Hz, flagged in status
// RULE4: rate pulses counted over a one-second gate, then published
// RULE5: rate contact closes once a reading above the setpoint is taken
// RULE6: rate contact opens when a later reading falls below setpoint
// RULE7: removing rate enable clears the actual value to zero
// RULE8: rate reset coil forces the actual value to zero
// RULE9: direction coil has no effect in rate mode
// RULE10: each channel counts from its own fixed input pin
// RULE11: pulse source keeps the input rate at or below 1 kHz
// RULE12: each high and low phase lasts at least 0.5 ms
// RULE13: counting runs freely; contacts hand over once per scan
// RULE14: up/down contact closed while actual is at least setpoint
// RULE15: up/down counter counts only while enable is 1
// RULE16: direction 0 counts up, direction 1 counts down
// RULE17: up/down setpoint accepts 0 to 32000, larger writes clamp
// RULE18: up/down value saturates at 32000 and at 0, never wraps
// RULE19: value holds when no pulses arrive or enable is absent
// RULE20: counting down, contact opens at one below the setpoint
// RULE21: reset coil holds value at zero and ignores pulses
// RULE22: retentive value survives run to stop and can be restored
// RULE23: each rising edge moves the value by exactly one
// RULE24: inputs are synchronised before edge detection
`timescale 1ns/100ps
module fast_counters
    import fast_counters_pkg::*;
#(
    parameter int unsigned GATE_CYCLES = GATE_CYCLES_DFLT
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pulse inputs
    input wire logic count_input_a,
    input wire logic count_input_b,
    input wire logic rate_input_a,
    input wire logic rate_input_b,
    // contacts as handed to the program at each scan
    output logic [NUM_CH-1:0] threshold_contact
);
    localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);

    chan_ctrl_t ctrl [NUM_CH];
    count_t setpoint [NUM_CH];
    count_t actual [NUM_CH];
    count_t pulse_cnt [NUM_CH];
    logic [31:0] gate_cnt [NUM_CH];
    logic [NUM_CH-1:0] rate_hit;
    logic [NUM_CH-1:0] range_ok;
    logic run;
    logic run_prev;
    logic [NUM_CH-1:0] sync_a;
    logic [NUM_CH-1:0] sync_b;
    logic [NUM_CH-1:0] sync_c;
    logic [NUM_CH-1:0] pulse_in;
    logic [NUM_CH-1:0] pulse_edge;
    logic [NUM_CH-1:0] rate_active;
    logic [NUM_CH-1:0] gate_done;
    logic [NUM_CH-1:0] contact_now;
    logic [NUM_CH-1:0] wr_ctrl;
    logic [NUM_CH-1:0] wr_setpoint;
    logic [NUM_CH-1:0] wr_actual;
    logic access;
    logic commit;
    logic wr;
    logic stop_edge;
    logic [31:0] read_word;

    function automatic count_t sp_limit(logic [7:0] mode, count_t v);
        count_t lim;
        lim = (mode == MODE_RATE) ? RATE_SP_MAX : UPDOWN_MAX;
        return (v > lim) ? lim : v;
    endfunction

    function automatic count_t updown_step(count_t v, logic down);
        if (down)
        begin
            return (v == 16'h0000) ? v : count_t'(v - 16'h0001);
        end
        return (v >= UPDOWN_MAX) ? UPDOWN_MAX : count_t'(v + 16'h0001);
    endfunction

    function automatic count_t sat_add(count_t v, logic inc);
        if (inc && v != COUNT_SAT)
        begin
            return count_t'(v + 16'h0001);
        end
        return v;
    endfunction

    function automatic logic addr_ok(logic [7:0] a);
        return (a[7:6] == 2'b00) || a == ADDR_RUN || a == ADDR_SCAN;
    endfunction

    function automatic logic chan_hit(logic [7:0] a, int ch,
                                      logic [1:0] ofs);
        return a[7:6] == 2'b00 && a[5:4] == 2'(ch) && a[3:2] == ofs;
    endfunction

    // fixed pin per channel: 0,1 up/down, 2,3 rate
    assign pulse_in = {rate_input_b, rate_input_a,
                       count_input_b, count_input_a}; // RULE10

    // two-stage synchroniser, third stage for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end
        else
        begin
            sync_a <= pulse_in; // RULE24
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign pulse_edge = sync_b & ~sync_c; // RULE23

    // apb handshake: one wait state, data and error registered
    assign access = psel & penable;
    assign commit = access & pready;
    assign wr = commit & pwrite & addr_ok(paddr);
    assign stop_edge = run_prev & ~run;

    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            wr_ctrl[i] = wr && chan_hit(paddr, i, OFS_CTRL);
            wr_setpoint[i] = wr && chan_hit(paddr, i, OFS_SETPOINT);
            wr_actual[i] = wr && chan_hit(paddr, i, OFS_ACTUAL);
            rate_active[i] = run && ctrl[i].enable &&
                             !ctrl[i].reset_coil &&
                             ctrl[i].mode == MODE_RATE;
            gate_done[i] = rate_active[i] && gate_cnt[i] == GATE_LAST;
            if (ctrl[i].mode == MODE_UPDOWN)
            begin
                contact_now[i] = actual[i] >= setpoint[i]; // RULE14 RULE20
            end
            else
            begin
                contact_now[i] = rate_hit[i];
            end
        end
    end

    always_comb
    begin
        read_word = 32'h0000_0000;
        if (paddr == ADDR_RUN)
        begin
            read_word = {31'h0000_0000, run};
        end
        else if (paddr == ADDR_SCAN)
        begin
            read_word = {28'h000_0000, threshold_contact};
        end
        else if (paddr[7:6] == 2'b00)
        begin
            unique case (paddr[3:2])
                OFS_CTRL: read_word = {20'h0_0000, ctrl[paddr[5:4]]};
                OFS_SETPOINT: read_word = {16'h0000, setpoint[paddr[5:4]]};
                OFS_ACTUAL: read_word = {16'h0000, actual[paddr[5:4]]};
                OFS_STATUS:
                    read_word = {30'h0000_0000, range_ok[paddr[5:4]],
                                 contact_now[paddr[5:4]]};
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~addr_ok(paddr);
            if (access && !pready)
            begin
                prdata <= addr_ok(paddr) ? read_word : 32'h0000_0000;
            end
        end
    end

    // run / stop state of the control program
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= RUN_RST;
            run_prev <= RUN_RST;
        end
        else
        begin
            run_prev <= run;
            if (wr && paddr == ADDR_RUN)
            begin
                run <= pwdata[0];
            end
        end
    end

    // control words; unknown mode codes leave the mode unchanged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                ctrl[i] <= (i < 2) ? CTRL_RST_UPDOWN : CTRL_RST_RATE;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (wr_ctrl[i])
                begin
                    ctrl[i][3:0] <= pwdata[3:0];
                    if (pwdata[11:4] == MODE_RATE ||
                        pwdata[11:4] == MODE_UPDOWN)
                    begin
                        ctrl[i].mode <= pwdata[11:4]; // RULE1
                    end
                end
            end
        end
    end

    // setpoints, clamped to the range of the current mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                setpoint[i] <= SETPOINT_RST;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (wr_setpoint[i])
                begin
                    setpoint[i] <= sp_limit(ctrl[i].mode,
                                            pwdata[15:0]); // RULE2 RULE17
                end
                else if (wr_ctrl[i] && (pwdata[11:4] == MODE_RATE ||
                                        pwdata[11:4] == MODE_UPDOWN))
                begin
                    setpoint[i] <= sp_limit(pwdata[11:4], setpoint[i]);
                end
            end
        end
    end

    // gate timer and pulse accumulator, free of the scan
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                gate_cnt[i] <= 32'h0000_0000;
                pulse_cnt[i] <= 16'h0000;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (!rate_active[i])
                begin
                    gate_cnt[i] <= 32'h0000_0000;
                    pulse_cnt[i] <= 16'h0000;
                end
                else if (gate_done[i])
                begin
                    gate_cnt[i] <= 32'h0000_0000; // RULE4
                    pulse_cnt[i] <= 16'h0000;
                end
                else
                begin
                    gate_cnt[i] <= gate_cnt[i] + 32'h0000_0001;
                    pulse_cnt[i] <= sat_add(pulse_cnt[i], pulse_edge[i]);
                end
            end
        end
    end

    // actual values of both modes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                actual[i] <= 16'h0000;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (ctrl[i].mode == MODE_UPDOWN)
                begin
                    if (ctrl[i].reset_coil)
                    begin
                        actual[i] <= 16'h0000; // RULE21
                    end
                    else if (wr_actual[i] && !run)
                    begin
                        actual[i] <= sp_limit(MODE_UPDOWN,
                                              pwdata[15:0]); // RULE22
                    end
                    else if (stop_edge && !ctrl[i].retentive)
                    begin
                        actual[i] <= 16'h0000; // RULE22
                    end
                    else if (run && ctrl[i].enable && pulse_edge[i])
                    begin
                        // RULE15 RULE16 RULE18 RULE19 RULE23
                        actual[i] <= updown_step(actual[i],
                                                 ctrl[i].direction);
                    end
                end
                else
                begin
                    if (!ctrl[i].enable)
                    begin
                        actual[i] <= 16'h0000; // RULE7
                    end
                    else if (ctrl[i].reset_coil)
                    begin
                        actual[i] <= 16'h0000; // RULE8
                    end
                    else if (stop_edge && !ctrl[i].retentive)
                    begin
                        actual[i] <= 16'h0000;
                    end
                    else if (gate_done[i])
                    begin
                        // RULE4 RULE9
                        actual[i] <= sat_add(pulse_cnt[i], pulse_edge[i]);
                    end
                end
            end
        end
    end

    // rate contact and validity flag, updated at each gate end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rate_hit <= '0;
            range_ok <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (ctrl[i].mode != MODE_RATE || !ctrl[i].enable ||
                    ctrl[i].reset_coil)
                begin
                    rate_hit[i] <= 1'b0;
                    range_ok[i] <= 1'b0;
                end
                else if (gate_done[i])
                begin
                    if (sat_add(pulse_cnt[i], pulse_edge[i]) > setpoint[i])
                    begin
                        rate_hit[i] <= 1'b1; // RULE5
                    end
                    else if (sat_add(pulse_cnt[i], pulse_edge[i]) <
                             setpoint[i])
                    begin
                        rate_hit[i] <= 1'b0; // RULE6
                    end
                    range_ok[i] <=
                        sat_add(pulse_cnt[i], pulse_edge[i]) >=
                            RATE_VALID_MIN &&
                        sat_add(pulse_cnt[i], pulse_edge[i]) <=
                            RATE_VALID_MAX; // RULE3
                end
            end
        end
    end

    // contacts are handed over only when the program strobes a scan
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            threshold_contact <= '0;
        end
        else if (wr && paddr == ADDR_SCAN)
        begin
            threshold_contact <= contact_now; // RULE13
        end
    end
endmodule

// file: pulse_source.sv
// pulse sources standing on the four counter input pins
`timescale 1ns/100ps
module pulse_source #(
    parameter int HALF = 20000
)
(
    // clock
    input wire logic pclk,
    // square wave request, bits 2 and 3 only; the up/down pins ignore it
    input wire logic [3:0] free_run,
    // pins
    output logic [3:0] pin
);
    int cnt = 0;

    initial pin = 4'h0;

    // rate pins: square wave with equal high and low phases
    always @(posedge pclk)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
        begin
            pin[2] <= free_run[2] & ~pin[2];
            pin[3] <= free_run[3] & ~pin[3];
        end
    end

    // n whole pulses on one pin, each phase HALF cycles long
    task automatic send(input int ch, input int n);
        repeat (2 * n)
        begin
            pin[ch] <= ~pin[ch];
            repeat (HALF) @(posedge pclk);
        end
    endtask
endmodule

// file: fast_counters_sva.sv
// bus and contact checks for the counter block
`timescale 1ns/100ps
module fast_counters_sva
    import fast_counters_pkg::*;
#(
    parameter int unsigned GATE_CYCLES = GATE_CYCLES_DFLT
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and contacts
    input wire logic count_input_a,
    input wire logic count_input_b,
    input wire logic rate_input_a,
    input wire logic rate_input_b,
    input wire logic [NUM_CH-1:0] threshold_contact
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic acc;
    logic rd;
    logic scan_wr;
    assign acc = psel && penable && pready;
    assign rd = acc && !pwrite;
    assign scan_wr = acc && pwrite && paddr[7:2] == 6'h11;

    a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (acc |-> pslverr ==
        !(paddr[7:6] == 2'b00 || paddr == 8'h40 || paddr == 8'h44))
        else $error("pslverr does not match address map");
    a_err_data: assert property (rd && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_contact_hold: assert property (
        !scan_wr |=> $stable(threshold_contact))
        else $error("contacts changed without scan handover");
    a_scan_read: assert property (
        rd && paddr[7:2] == 6'h11 |-> prdata[3:0] == threshold_contact)
        else $error("scan read differs from contacts");
    a_updown_range: assert property (
        rd && paddr[7:2] inside {6'h01, 6'h02, 6'h05, 6'h06}
        |-> prdata <= {16'h0, UPDOWN_MAX})
        else $error("up/down value above range");
    a_rate_sp_range: assert property (
        rd && paddr[7:2] inside {6'h09, 6'h0D} |-> prdata <= 32'h3E8)
        else $error("rate setpoint above range");
endmodule

bind fast_counters fast_counters_sva #(.GATE_CYCLES(GATE_CYCLES)) i_sva (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_input_a(count_input_a), .count_input_b(count_input_b),
    .rate_input_a(rate_input_a), .rate_input_b(rate_input_b),
    .threshold_contact(threshold_contact)
);

// file: test_fast_freq_and_updown_counters.sv
// testbench for the pulse rate and up/down counter block
`timescale 1ns/100ps
module test_fast_freq_and_updown_counters;
    import fast_counters_pkg::*;
    localparam int GATE = 1000;
    typedef struct {
        int ch;
        logic [3:0] ctrl;
        count_t pre;
        count_t sp;
        int n;
        count_t exp;
        logic hit;
    } row_t;
    // ctrl bits: enable, reset coil, direction, retentive
    row_t rows [7] = '{
        '{0, 4'h1, 16'h0000, 16'h0003, 5, 16'h0005, 1'b1},
        '{1, 4'h5, 16'h0201, 16'h0200, 2, 16'h01FF, 1'b0},
        '{0, 4'h5, 16'h0001, 16'h0000, 3, 16'h0000, 1'b1},
        '{1, 4'h1, 16'h7CFF, 16'h7D00, 3, 16'h7D00, 1'b1},
        '{0, 4'h0, 16'h0007, 16'h0008, 3, 16'h0007, 1'b0},
        '{0, 4'h3, 16'h0007, 16'h0001, 3, 16'h0000, 1'b0},
        '{1, 4'h1, 16'h01FE, 16'h0200, 2, 16'h0200, 1'b1}
    };
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pin;
    logic [3:0] free_run = 4'h0;
    logic [NUM_CH-1:0] threshold_contact;
    logic [31:0] q;
    logic e;
    logic [7:0] b;
    int miscompares = 0;
    int total_checks = 0;

    always #12.5 pclk = ~pclk;

    pulse_source #(.HALF(10)) i_src (
        .pclk(pclk), .free_run(free_run), .pin(pin)
    );

    fast_counters #(.GATE_CYCLES(GATE)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_input_a(pin[0]), .count_input_b(pin[1]),
        .rate_input_a(pin[2]), .rate_input_b(pin[3]),
        .threshold_contact(threshold_contact)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        if (n == 20)
            check(1'b0, 1'b1, "apb answer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        complete_run();
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            b = 8'(rows[i].ch * 16);
            apb(ADDR_RUN, 1'b1, 32'h0);
            apb(b, 1'b1, {20'h0, MODE_UPDOWN, rows[i].ctrl});
            apb(b + 8'h4, 1'b1, {16'h0, rows[i].sp});
            apb(b + 8'h8, 1'b1, {16'h0, rows[i].pre});
            apb(ADDR_RUN, 1'b1, 32'h1);
            i_src.send(rows[i].ch, rows[i].n);
            apb(b + 8'h8, 1'b0, 32'h0);
            check(q, {16'h0, rows[i].exp}, "actual");
            apb(b + 8'hC, 1'b0, 32'h0);
            check(q[0], rows[i].hit, "contact");
            $display("row %0d done", i);
        end
        // reset values, refused address, setpoint clamps
        apb(8'h20, 1'b0, 32'h0);
        check(q, 32'h0000_0460, "rate mode code");
        apb(8'h4C, 1'b0, 32'h0);
        check({31'h0, e}, 32'h1, "unmapped error");
        check(q, 32'h0, "unmapped data");
        apb(8'h04, 1'b1, 32'h0000_9C40);
        apb(8'h04, 1'b0, 32'h0);
        check(q, 32'h0000_7D00, "updown clamp");
        apb(8'h24, 1'b1, 32'h0000_07D0);
        apb(8'h24, 1'b0, 32'h0);
        check(q, 32'h0000_03E8, "rate clamp");
        $display("register test done");
        // retentive value survives run to stop
        apb(ADDR_RUN, 1'b1, 32'h0);
        apb(8'h00, 1'b1, 32'h0000_0489);
        apb(8'h08, 1'b1, 32'h0000_01C2);
        apb(8'h10, 1'b1, 32'h0000_0481);
        apb(8'h18, 1'b1, 32'h0000_01C2);
        apb(ADDR_RUN, 1'b1, 32'h1);
        apb(ADDR_RUN, 1'b1, 32'h0);
        apb(8'h08, 1'b0, 32'h0);
        check(q, 32'h0000_01C2, "retained");
        apb(8'h18, 1'b0, 32'h0);
        check(q, 32'h0, "not retained");
        $display("retention test done");
        // rate channel, direction coil set and ignored
        apb(8'h20, 1'b1, 32'h0000_0465);
        apb(8'h24, 1'b1, 32'h0000_000A);
        apb(8'h30, 1'b1, 32'h0000_0461);
        apb(ADDR_RUN, 1'b1, 32'h1);
        free_run <= 4'hC;
        repeat (2 * GATE + 100) @(posedge pclk);
        apb(8'h28, 1'b0, 32'h0);
        check(q >= 49 && q <= 51, 1'b1, "rate reading");
        apb(8'h38, 1'b0, 32'h0);
        check(q >= 49 && q <= 51, 1'b1, "rate b reading");
        apb(8'h2C, 1'b0, 32'h0);
        check(q[1:0], 2'b11, "rate status");
        check(threshold_contact[2], 1'b0, "before scan");
        apb(ADDR_SCAN, 1'b1, 32'h0);
        // contacts settle after the committing edge
        @(posedge pclk);
        check(threshold_contact[2], 1'b1, "after scan");
        check(threshold_contact[3], 1'b1, "after scan b");
        apb(8'h24, 1'b1, 32'h0000_0064);
        repeat (GATE + 100) @(posedge pclk);
        apb(8'h2C, 1'b0, 32'h0);
        check(q[0], 1'b0, "rate contact opens");
        apb(8'h20, 1'b1, 32'h0000_0464);
        apb(8'h28, 1'b0, 32'h0);
        check(q, 32'h0, "enable removed");
        apb(8'h20, 1'b1, 32'h0000_0465);
        repeat (GATE + 100) @(posedge pclk);
        apb(8'h28, 1'b0, 32'h0);
        check(q >= 49 && q <= 51, 1'b1, "rate re-enabled");
        apb(8'h20, 1'b1, 32'h0000_0467);
        apb(8'h28, 1'b0, 32'h0);
        check(q, 32'h0, "rate reset coil");
        $display("rate test done");
        complete_run();
    end
endmodule
